// ---- rtl/smkt_core.sv ----
// What this block does
// - count step pulses to select test mode
// - each further step pulse advances mode, holding at 0x1F
// - 2 ms trigger runs dark then lit
// - verify compares difference against selected limit
// - route monitors in verify, drift measure and calibrate modes, result in test modes
// - drift measure adds difference to counter
// - latch with entry low stores baseline
// - entry pulse increments drift counter
// - latch with entry high stores ceiling
// - drift program writes drift values to eeprom
// - one calibrate mode per alarm limit
// - trigger fall increments dac, 2 ms trigger hold starts measure
// - result high when dac below amplifier
// - 10 us latch stores dac as limit
// - silence latch 10 ms programs all limits
// - dac counter wraps at 64
// - four limits plus baseline and ceiling held
`timescale 1ns/10ps
`default_nettype none
module smkt_core #(
  parameter int TRIG_CYC = smkt_pkg::TRIG_MIN_CYC,
  parameter int PROG_CYC = smkt_pkg::PROG_MIN_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // probe pins
  input wire logic mode_entry_pin,
  input wire logic mode_step_pin,
  input wire logic measure_trigger_pin,
  input wire logic latch_program_pin,
  output logic probe_result_pin,
  // analog front end
  input wire logic [5:0] meas_diff,
  input wire logic amp_above_dac,
  output logic infrared_emitter,
  output logic integrator_monitor_pin,
  output logic dac_monitor_pin,
  output logic [5:0] dac_level,
  // eeprom
  output logic eeprom_prog,
  output logic eeprom_drift_sel,
  output logic [35:0] eeprom_word,
  // axi4-lite slave
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  // ==========================================
  // synchronisers
  localparam logic [19:0] TRIG_N = 20'(TRIG_CYC);
  localparam logic [19:0] PROG_N = 20'(PROG_CYC);
  localparam logic [19:0] LATCH_N = 20'(smkt_pkg::LATCH_MIN_CYC);
  localparam logic [19:0] PHASE_N = 20'(smkt_pkg::PHASE_CYC);
  logic [4:0] s1_r, s2_r, s3_r;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_r <= 5'h00;
      s2_r <= 5'h00;
      s3_r <= 5'h00;
    end
    else
    begin
      s1_r <= {amp_above_dac, latch_program_pin, measure_trigger_pin, mode_step_pin, mode_entry_pin};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  logic entry_hi, step_rise, trig_hi, trig_fall, latch_hi, latch_rise, entry_fall, cmp_hi, entry_rise;
  assign entry_hi = s2_r[0];
  assign entry_rise = s2_r[0] && !s3_r[0];
  assign entry_fall = s3_r[0] && !s2_r[0];
  assign step_rise = s2_r[1] && !s3_r[1];
  assign trig_hi = s2_r[2];
  assign trig_fall = s3_r[2] && !s2_r[2];
  assign latch_hi = s2_r[3];
  assign latch_rise = s2_r[3] && !s3_r[3];
  assign cmp_hi = s2_r[4];
  // ==========================================
  // mode selection
  logic [4:0] mode_r;
  logic armed_r, test_en_r;
  logic is_verify, is_drift, is_cal, is_test;
  assign is_verify = mode_r >= smkt_pkg::VERIFY_CHAMBER_MODE && mode_r <= smkt_pkg::VERIFY_SILENCE_MODE;
  assign is_drift = mode_r == smkt_pkg::DRIFT_MEASURE_MODE;
  assign is_cal = mode_r >= smkt_pkg::CALIBRATE_CHAMBER_MODE && mode_r <= smkt_pkg::CALIBRATE_SILENCE_MODE;
  assign is_test = is_verify || is_drift || is_cal || mode_r == smkt_pkg::DRIFT_PROGRAM_MODE;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_r <= smkt_pkg::NORMAL_POWER_UP_STATE;
      armed_r <= 1'b0;
    end
    else if (test_en_r && entry_hi && step_rise)
    begin
      if (!armed_r)
        armed_r <= 1'b1;
      else if (mode_r != smkt_pkg::MODE_MAX)
        mode_r <= mode_r + 5'h01;
    end
  end
  // ==========================================
  // trigger and latch hold timers
  logic [19:0] trig_cnt_r, latch_cnt_r;
  logic trig_done, latch_short, latch_long;
  assign trig_done = trig_hi && trig_cnt_r == TRIG_N - 20'h00001;
  assign latch_short = latch_hi && latch_cnt_r == LATCH_N - 20'h00001;
  assign latch_long = latch_hi && latch_cnt_r == PROG_N - 20'h00001;
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !trig_hi)
      trig_cnt_r <= 20'h00000;
    else if (trig_cnt_r != TRIG_N)
      trig_cnt_r <= trig_cnt_r + 20'h00001;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !latch_hi)
      latch_cnt_r <= 20'h00000;
    else if (latch_cnt_r != PROG_N)
      latch_cnt_r <= latch_cnt_r + 20'h00001;
  end
  // ==========================================
  // dark then lit measurement
  smkt_pkg::smkt_meas_type m_st, m_nxt;
  logic [19:0] phase_r;
  logic meas_go, phase_end;
  assign meas_go = trig_done && !entry_hi && (is_verify || is_drift || is_cal);
  assign phase_end = phase_r == PHASE_N - 20'h00001;
  always_comb
  begin
    m_nxt = m_st;
    case (m_st)
      smkt_pkg::M_IDLE: if (meas_go) m_nxt = smkt_pkg::M_DARK;
      smkt_pkg::M_DARK: if (phase_end) m_nxt = smkt_pkg::M_LIT;
      smkt_pkg::M_LIT: if (phase_end) m_nxt = smkt_pkg::M_DONE;
      default: m_nxt = smkt_pkg::M_IDLE;
    endcase
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      m_st <= smkt_pkg::M_IDLE;
      phase_r <= 20'h00000;
      infrared_emitter <= 1'b0;
    end
    else
    begin
      m_st <= m_nxt;
      phase_r <= (m_nxt != m_st) ? 20'h00000 : phase_r + 20'h00001;
      infrared_emitter <= m_nxt == smkt_pkg::M_LIT;
    end
  end
  // ==========================================
  // limits, drift values and dac
  logic [5:0] limit_r [4];
  logic [5:0] drift_cnt_r, baseline_r, ceiling_r, lim_sel;
  assign lim_sel = limit_r[mode_r[1:0]];
  // only a full low-high-low entry pulse counts, not the fall that starts measuring
  logic entry_seen_r, drift_tick;
  assign drift_tick = is_drift && entry_fall && entry_seen_r;
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !is_drift)
      entry_seen_r <= 1'b0;
    else if (entry_rise)
      entry_seen_r <= 1'b1;
    else if (entry_fall)
      entry_seen_r <= 1'b0;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      drift_cnt_r <= 6'h00;
    else if (is_drift)
      drift_cnt_r <= drift_cnt_r + (m_st == smkt_pkg::M_DONE ? meas_diff : 6'h00)
        + {5'h00, drift_tick};
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      baseline_r <= 6'h00;
      ceiling_r <= 6'h00;
    end
    else if (is_drift && latch_rise && !trig_hi)
    begin
      if (entry_hi)
        ceiling_r <= drift_cnt_r;
      else
        baseline_r <= drift_cnt_r;
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      dac_level <= 6'h00;
    else if (!is_cal)
      dac_level <= 6'h00;
    else if (trig_fall)
      dac_level <= dac_level + 6'h01;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      for (int i = 0; i < 4; i++)
        limit_r[i] <= 6'h00;
    else if (is_cal && latch_short && !trig_hi)
      limit_r[mode_r[1:0]] <= dac_level;
  end
  // ==========================================
  // result, monitors and eeprom
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !is_test)
      probe_result_pin <= 1'b0;
    else if (is_cal)
      probe_result_pin <= cmp_hi;
    else if (is_verify && meas_go)
      probe_result_pin <= 1'b0;
    else if (is_verify && m_st == smkt_pkg::M_DONE)
      probe_result_pin <= meas_diff > lim_sel;
    else if (is_drift)
      probe_result_pin <= cmp_hi;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      integrator_monitor_pin <= 1'b0;
      dac_monitor_pin <= 1'b0;
    end
    else
    begin
      integrator_monitor_pin <= is_verify || is_drift || is_cal;
      dac_monitor_pin <= is_verify || is_drift || is_cal;
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      eeprom_prog <= 1'b0;
      eeprom_drift_sel <= 1'b0;
      eeprom_word <= 36'h000000000;
    end
    else
    begin
      eeprom_prog <= 1'b0;
      if (latch_long && !entry_hi && mode_r == smkt_pkg::DRIFT_PROGRAM_MODE)
      begin
        eeprom_prog <= 1'b1;
        eeprom_drift_sel <= 1'b1;
        eeprom_word <= {ceiling_r, baseline_r, limit_r[0], limit_r[3], limit_r[2], limit_r[1]};
      end
      else if (latch_long && !trig_hi && mode_r == smkt_pkg::CALIBRATE_SILENCE_MODE)
      begin
        eeprom_prog <= 1'b1;
        eeprom_drift_sel <= 1'b0;
        eeprom_word <= {ceiling_r, baseline_r, limit_r[0], limit_r[3], limit_r[2], limit_r[1]};
      end
    end
  end
  // ==========================================
  // axi4-lite registers
  logic aw_hold_r, w_hold_r;
  logic [7:0] wa_r;
  logic [31:0] wd_r;
  logic [3:0] ws_r;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b0;
      wready <= 1'b0;
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      wa_r <= 8'h00;
      wd_r <= 32'h00000000;
      ws_r <= 4'h0;
      bvalid <= 1'b0;
      bresp <= smkt_pkg::RESP_OKAY;
      test_en_r <= smkt_pkg::CTRL_RESET;
    end
    else
    begin
      awready <= !aw_hold_r && !(awvalid && awready) && !bvalid;
      wready <= !w_hold_r && !(wvalid && wready) && !bvalid;
      if (awvalid && awready)
      begin
        aw_hold_r <= 1'b1;
        wa_r <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_hold_r <= 1'b1;
        wd_r <= wdata;
        ws_r <= wstrb;
      end
      if (aw_hold_r && w_hold_r && !bvalid)
      begin
        bvalid <= 1'b1;
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        bresp <= smkt_pkg::RESP_OKAY;
        if (wa_r == smkt_pkg::REG_CTRL)
          test_en_r <= ws_r[0] ? wd_r[0] : test_en_r;
        else if (wa_r != smkt_pkg::REG_STATUS && wa_r != smkt_pkg::REG_LIMITS && wa_r != smkt_pkg::REG_DRIFT)
          bresp <= smkt_pkg::RESP_SLVERR;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= smkt_pkg::RESP_OKAY;
    end
    else
    begin
      arready <= !rvalid && !(arvalid && arready);
      if (arvalid && arready)
      begin
        rvalid <= 1'b1;
        rresp <= smkt_pkg::RESP_OKAY;
        case (araddr)
          smkt_pkg::REG_CTRL: rdata <= {31'h00000000, test_en_r};
          smkt_pkg::REG_STATUS: rdata <= {18'h00000, dac_level, m_st != smkt_pkg::M_IDLE, probe_result_pin,
            armed_r, mode_r};
          smkt_pkg::REG_LIMITS: rdata <= {8'h00, limit_r[3], limit_r[2], limit_r[1], limit_r[0]};
          smkt_pkg::REG_DRIFT: rdata <= {14'h0000, drift_cnt_r, ceiling_r, baseline_r};
          default:
          begin
            rdata <= 32'h00000000;
            rresp <= smkt_pkg::RESP_SLVERR;
          end
        endcase
      end
      else if (rvalid && rready)
        rvalid <= 1'b0;
    end
  end
  // ==========================================
  // checks
  chk_mode_step_count: assert property (@(posedge aclk) disable iff (!aresetn)
    (test_en_r && entry_hi && step_rise && armed_r && mode_r != 5'h1F) |=> mode_r == $past(mode_r) + 5'h01)
    else $error("mode did not advance on step pulse");
  chk_emitter_after_dark: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(infrared_emitter) |-> m_st == smkt_pkg::M_LIT && $past(m_st, 2) == smkt_pkg::M_DARK)
    else $error("emitter lit without dark phase");
  chk_verify_result: assert property (@(posedge aclk) disable iff (!aresetn)
    (is_verify && m_st == smkt_pkg::M_DONE) |=> probe_result_pin == ($past(meas_diff) > $past(lim_sel)))
    else $error("verify result mismatch");
  chk_monitor_route: assert property (@(posedge aclk) disable iff (!aresetn)
    (is_cal ##1 is_cal) |-> integrator_monitor_pin && dac_monitor_pin)
    else $error("monitors not routed");
  chk_drift_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
    (drift_tick && m_st != smkt_pkg::M_DONE) |=> drift_cnt_r == $past(drift_cnt_r) + 6'h01)
    else $error("drift counter did not step");
  chk_baseline_latch: assert property (@(posedge aclk) disable iff (!aresetn)
    (is_drift && latch_rise && !trig_hi && !entry_hi) |=> baseline_r == $past(drift_cnt_r))
    else $error("baseline not latched");
  chk_ceiling_latch: assert property (@(posedge aclk) disable iff (!aresetn)
    (is_drift && latch_rise && !trig_hi && entry_hi) |=> ceiling_r == $past(drift_cnt_r))
    else $error("ceiling not latched");
  chk_dac_wrap_step: assert property (@(posedge aclk) disable iff (!aresetn)
    (is_cal && trig_fall && mode_r == $past(mode_r)) |=> dac_level == $past(dac_level) + 6'h01)
    else $error("dac did not step");
  chk_cal_compare: assert property (@(posedge aclk) disable iff (!aresetn)
    (is_cal ##1 is_cal) |-> probe_result_pin == $past(cmp_hi))
    else $error("calibration result wrong");
  chk_limit_store: assert property (@(posedge aclk) disable iff (!aresetn)
    (is_cal && latch_short && !trig_hi) |=> limit_r[mode_r[1:0]] == $past(dac_level))
    else $error("limit not stored");
endmodule : smkt_core
`default_nettype wire

// ---- common/smkt_pkg.sv ----
package smkt_pkg;
  // ==========================================
  // timing
  localparam int CLK_MHZ = 100;
  localparam int TRIG_MIN_MS = 2;
  localparam int TRIG_MIN_CYC = TRIG_MIN_MS * 1000 * CLK_MHZ;
  localparam int PROG_MIN_MS = 10;
  localparam int PROG_MIN_CYC = PROG_MIN_MS * 1000 * CLK_MHZ;
  localparam int LATCH_MIN_US = 10;
  localparam int LATCH_MIN_CYC = LATCH_MIN_US * CLK_MHZ;
  localparam int PHASE_US = 20;
  localparam int PHASE_CYC = PHASE_US * CLK_MHZ;
  localparam int CNT_W = 20;
  // ==========================================
  // test modes
  localparam int MODE_W = 5;
  localparam logic [4:0] NORMAL_POWER_UP_STATE = 5'h00;
  localparam logic [4:0] VERIFY_CHAMBER_MODE = 5'h04;
  localparam logic [4:0] VERIFY_SILENCE_MODE = 5'h07;
  localparam logic [4:0] DRIFT_MEASURE_MODE = 5'h0A;
  localparam logic [4:0] DRIFT_PROGRAM_MODE = 5'h0B;
  localparam logic [4:0] CALIBRATE_CHAMBER_MODE = 5'h0C;
  localparam logic [4:0] CALIBRATE_SILENCE_MODE = 5'h0F;
  localparam logic [4:0] MODE_MAX = 5'h1F;
  localparam int LIMIT_W = 6;
  // ==========================================
  // register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_LIMITS = 8'h08;
  localparam logic [7:0] REG_DRIFT = 8'h0C;
  localparam logic CTRL_RESET = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {M_IDLE, M_DARK, M_LIT, M_DONE} smkt_meas_type;
endpackage : smkt_pkg

// ---- tb/smkt_front_end.sv ----
`timescale 1ns/10ps
`default_nettype none
module smkt_front_end (
  // clock
  input wire logic aclk,
  // device side
  input wire logic infrared_emitter,
  input wire logic [5:0] dac_level,
  // chamber smoke setting
  input wire logic [5:0] smoke_lvl,
  // front end results
  output logic [5:0] meas_diff,
  output logic amp_above_dac
);
  logic infrared_emitter_q = 1'b0;
  int hold_n = 0;
  always_ff @(posedge aclk)
  begin
    infrared_emitter_q <= infrared_emitter;
    if (infrared_emitter_q && !infrared_emitter)
      hold_n <= 16;
    else if (hold_n > 0)
      hold_n <= hold_n - 1;
  end
  // difference only valid just after the lit phase
  assign meas_diff = ((infrared_emitter_q && !infrared_emitter) || hold_n > 0) ? smoke_lvl : ~smoke_lvl;
  assign amp_above_dac = smoke_lvl > dac_level;
endmodule : smkt_front_end
`default_nettype wire

// ---- tb/smoke_limit_calibration_test_modes_test.sv ----
`timescale 1ns/10ps
`default_nettype none
module smoke_limit_calibration_test_modes_test;
  localparam int TRIG = 50;
  localparam int PROG = 3000;
  localparam int MEAS = 2 * smkt_pkg::PHASE_CYC + 20;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] pins = 4'h0;
  logic [5:0] smoke = 6'h09;
  logic [5:0] meas_diff, dac_level;
  logic amp_above_dac, probe_result_pin, infrared_emitter, integrator_monitor_pin, dac_monitor_pin;
  logic eeprom_prog, eeprom_drift_sel, prog_sel;
  logic [35:0] eeprom_word, prog_word;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, rd_val;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rd_resp;
  int fails = 0;
  int checked = 0;
  int lit_n = 0;
  int prog_n = 0;
  always #5 aclk = ~aclk;
  // ==========================================
  // design and front end
  smkt_core #(.TRIG_CYC(TRIG), .PROG_CYC(PROG)) u_dut (.aclk(aclk), .aresetn(aresetn),
    .mode_entry_pin(pins[0]), .mode_step_pin(pins[1]), .measure_trigger_pin(pins[2]),
    .latch_program_pin(pins[3]), .probe_result_pin(probe_result_pin), .meas_diff(meas_diff),
    .amp_above_dac(amp_above_dac), .infrared_emitter(infrared_emitter),
    .integrator_monitor_pin(integrator_monitor_pin), .dac_monitor_pin(dac_monitor_pin),
    .dac_level(dac_level), .eeprom_prog(eeprom_prog), .eeprom_drift_sel(eeprom_drift_sel),
    .eeprom_word(eeprom_word), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  smkt_front_end u_fe (.aclk(aclk), .infrared_emitter(infrared_emitter), .dac_level(dac_level),
    .smoke_lvl(smoke), .meas_diff(meas_diff), .amp_above_dac(amp_above_dac));
  always @(posedge aclk)
  begin
    if (infrared_emitter === 1'b1)
      lit_n++;
    if (eeprom_prog === 1'b1)
    begin
      prog_n++;
      prog_word = eeprom_word;
      prog_sel = eeprom_drift_sel;
    end
  end
  // ==========================================
  // tasks
  task cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc
  task pin(input int k, input logic v, input int n);
    pins[k] <= v;
    cyc(n);
  endtask : pin
  task pls(input int k, input logic v, input int n);
    pin(k, v, n);
    pin(k, !v, n);
  endtask : pls
  task step_pulse;
    pls(1, 1'b0, 4);
  endtask : step_pulse
  task check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    bready <= 1'b0;
    if (n >= 100)
      fails++;
    check({30'h0, bresp}, {30'h0, er});
  endtask : wr
  task rd(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (arready === 1'b1)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    rready <= 1'b0;
    rd_val = rdata;
    rd_resp = rresp;
    if (n >= 100)
      fails++;
  endtask : rd
  task mode_is(input int m);
    rd(smkt_pkg::REG_STATUS);
    check({27'h0, rd_val[4:0]}, m);
  endtask : mode_is
  task measure;
    lit_n = 0;
    pin(2, 1'b1, TRIG + 10);
    pin(2, 1'b0, MEAS);
  endtask : measure
  task print_verdict;
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  // ==========================================
  // tests
  initial
  begin
    #1000000;
    fails++;
    print_verdict;
  end
  initial
  begin
    cyc(8);
    aresetn <= 1'b1;
    cyc(3);
    rd(smkt_pkg::REG_CTRL);
    check(rd_val, 32'h1);
    rd(8'h40);
    check({rd_val[29:0], rd_resp}, {30'h0, smkt_pkg::RESP_SLVERR});
    wr(8'h40, 32'h0, smkt_pkg::RESP_SLVERR);
    wr(smkt_pkg::REG_STATUS, 32'hFFFFFFFF, smkt_pkg::RESP_OKAY);
    mode_is(0);
    pin(0, 1'b1, 8);
    pin(1, 1'b1, 8);
    repeat (4) step_pulse();
    mode_is(4);
    check({integrator_monitor_pin, dac_monitor_pin}, 32'h3);
    wr(smkt_pkg::REG_CTRL, 32'h0, smkt_pkg::RESP_OKAY);
    step_pulse();
    mode_is(4);
    wr(smkt_pkg::REG_CTRL, 32'h1, smkt_pkg::RESP_OKAY);
    for (int m = 4; m < 8; m++)
    begin
      smoke = m[0] ? 6'h00 : 6'h09;
      mode_is(m);
      pin(0, 1'b0, 8);
      measure();
      check(lit_n, smkt_pkg::PHASE_CYC);
      check(probe_result_pin, !m[0]);
      pin(0, 1'b1, 8);
      step_pulse();
    end
    repeat (2) step_pulse();
    mode_is(10);
    smoke = 6'h05;
    pin(0, 1'b0, 8);
    measure();
    pls(3, 1'b1, 8);
    repeat (2) pls(0, 1'b1, 8);
    pin(0, 1'b1, 8);
    pls(3, 1'b1, 8);
    rd(smkt_pkg::REG_DRIFT);
    check({14'h0, rd_val[17:0]}, 32'h71C5);
    step_pulse();
    mode_is(11);
    pin(0, 1'b0, 8);
    prog_n = 0;
    pls(3, 1'b1, PROG + 20);
    check({prog_n[3:0], prog_sel, prog_word[35:24]}, 32'h031C5);
    pin(0, 1'b1, 8);
    step_pulse();
    mode_is(12);
    pin(0, 1'b0, 8);
    smoke = 6'h02;
    cyc(8);
    check(probe_result_pin, 1'b1);
    for (int k = 1; k < 4; k++)
    begin
      pls(2, 1'b1, 4);
      cyc(8);
      check(dac_level, k);
      check(probe_result_pin, k < 2);
    end
    pls(3, 1'b1, 1100);
    rd(smkt_pkg::REG_LIMITS);
    check(rd_val[5:0], 32'h3);
    repeat (63) pls(2, 1'b1, 4);
    cyc(8);
    check(dac_level, 32'h2);
    pin(0, 1'b1, 8);
    repeat (3) step_pulse();
    mode_is(15);
    pin(0, 1'b0, 8);
    prog_n = 0;
    pls(3, 1'b1, PROG + 20);
    check({prog_n[3:0], prog_sel, prog_word[23:12]}, 32'h20C2);
    print_verdict;
  end
endmodule : smoke_limit_calibration_test_modes_test
`default_nettype wire
